//--- design/sac_pkg.sv
// Operation
// R1: Clock gate bit 2 supplies unit clock
// R2: Prescaler select low/high nibbles pick clocks
// R3: Operation clock equals system clock over 2^k
// R4: Enable starts channel, clears and unmasks interrupt
// R5: Interrupt fires at transfer end or empty
// R6: Software stops channel before transmit-only mode
// R7: Software stops channel, enables receive, end timing
// R8: Software stops channel, both directions, empty timing
// R9: Software masks interrupt, then stops channel
// R10: Busy output rises at last character start
// R11: Source select 0 transfer end, 1 empty
// R12: Stop trigger 1 clears enable; 0 ignored
// R13: Gated off: clocks inactive, prescaler frozen
`default_nettype none
package sac_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] SAC_OFS_PCE = 8'h00; // peripheral_clock_enable
	localparam logic [7:0] SAC_OFS_SPS = 8'h04; // serial_clock_prescaler_select
	localparam logic [7:0] SAC_OFS_CTL = 8'h08; // channel mode control
	localparam logic [7:0] SAC_OFS_START = 8'h0C; // write 1: channel enable
	localparam logic [7:0] SAC_OFS_STOP = 8'h10; // write 1: channel_stop_trigger
	localparam logic [7:0] SAC_OFS_CSTAT = 8'h14; // channel status, read only
	localparam logic [7:0] SAC_OFS_ISTAT = 8'h18; // sticky event status, read only
	localparam logic [7:0] SAC_OFS_ICLR = 8'h1C; // event clear, write only
	localparam logic [7:0] SAC_OFS_IEN = 8'h20; // event enable
	// ==========================================================
	// Field positions
	localparam int SAC_POS_GATE = 2; // serial_unit_clock_gate
	localparam int SAC_POS_SRC = 0; // interrupt_source_select
	localparam int SAC_POS_TXE = 1; // transmit enable
	localparam int SAC_POS_RXE = 2; // receive enable
	localparam int SAC_POS_MASK = 3; // channel interrupt mask
	localparam int SAC_POS_EN = 0; // channel_enable_status
	localparam int SAC_POS_BUSY = 1; // busy handshake level
	localparam int SAC_POS_PEND = 2; // channel interrupt pending
	localparam int SAC_EVT_N = 3; // number of sticky events
	// ==========================================================
	// Reset values
	localparam logic [7:0] SAC_RST_PCE = 8'h00;
	localparam logic [7:0] SAC_RST_SPS = 8'h00;
	localparam logic [3:0] SAC_RST_CTL = 4'h8; // Masked, transfer-end timing
	localparam logic [SAC_EVT_N-1:0] SAC_RST_IEN = 3'h0;
	// ==========================================================
	// AXI responses and widths
	localparam logic [1:0] SAC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SAC_RESP_SLVERR = 2'h2;
	localparam int SAC_PRE_W = 15; // prescaler counter bits for 2^15
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic last_start; // Master started the last character
		logic buf_empty; // Transmit buffer became empty
		logic xfer_end; // One character transfer ended
	} sac_evt_s;
	typedef struct packed {
		logic clk1; // operation_clock_one strobe
		logic clk0; // operation_clock_zero strobe
	} sac_opclk_s;
	typedef enum logic [1:0] {
		SAC_RD_IDLE,
		SAC_RD_RESP
	} sac_rd_e;
endpackage
`default_nettype wire

//--- design/sac_top.sv
`timescale 1ns/100ps
`default_nettype none
module sac_top #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire sac_pkg::sac_evt_s evt_i,
	output logic serial_unit_clock_en,
	output sac_pkg::sac_opclk_s op_clk,
	output logic channel_enable_status,
	output logic tx_enable,
	output logic rx_enable,
	output logic busy_out,
	output logic channel_transfer_interrupt,
	output logic irq
);
	import sac_pkg::*;

	// ==========================================================
	// Address decode
	// One decoder for both channels of the bus keeps read and write maps identical.
	function automatic logic [3:0] sac_sel(input logic [ADDR_W-1:0] a);
		logic [7:0] b;
		b = 8'(a);
		case (b)
			SAC_OFS_PCE: sac_sel = 4'h1;
			SAC_OFS_SPS: sac_sel = 4'h2;
			SAC_OFS_CTL: sac_sel = 4'h3;
			SAC_OFS_START: sac_sel = 4'h4;
			SAC_OFS_STOP: sac_sel = 4'h5;
			SAC_OFS_CSTAT: sac_sel = 4'h6;
			SAC_OFS_ISTAT: sac_sel = 4'h7;
			SAC_OFS_ICLR: sac_sel = 4'h8;
			SAC_OFS_IEN: sac_sel = 4'h9;
			default: sac_sel = 4'h0; // Unmapped
		endcase
	endfunction

	// ==========================================================
	// Write channel
	logic aw_have_q; // Write address captured
	logic w_have_q; // Write data captured
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic wr_fire; // Both halves present: commit this cycle
	logic [3:0] wr_sel;
	logic wr_lo; // Low byte lane written

	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_sel = sac_sel(aw_addr_q);
	assign wr_lo = wr_fire && w_strb_q[0];

	// Capture address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Write response, one cycle after commit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= SAC_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_sel == 4'h0 || wr_sel == 4'h6 || wr_sel == 4'h7) ? SAC_RESP_SLVERR : SAC_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration registers
	logic [7:0] pce_q; // peripheral_clock_enable
	logic [7:0] sps_q; // serial_clock_prescaler_select
	logic [3:0] ctl_q; // mask, rx, tx, source select
	logic [SAC_EVT_N-1:0] ien_q; // Event enable
	logic start_wr; // Software enable trigger
	logic stop_wr; // Software stop trigger
	logic gate; // serial_unit_clock_gate
	logic [3:0] code0; // prescaler_code_clock_zero
	logic [3:0] code1; // prescaler_code_clock_one

	assign start_wr = wr_lo && wr_sel == 4'h4 && w_data_q[SAC_POS_EN];
	assign stop_wr = wr_lo && wr_sel == 4'h5 && w_data_q[SAC_POS_EN]; // [R12]
	assign gate = pce_q[SAC_POS_GATE]; // [R1]
	assign code0 = sps_q[3:0]; // [R2]
	assign code1 = sps_q[7:4]; // [R2]

	// Clock enable and prescaler select
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pce_q <= SAC_RST_PCE;
			sps_q <= SAC_RST_SPS;
		end else begin
			if (wr_lo && wr_sel == 4'h1) begin
				pce_q <= w_data_q[7:0];
			end
			if (wr_lo && wr_sel == 4'h2) begin
				sps_q <= w_data_q[7:0];
			end
		end
	end

	// Mode control; enabling always unmasks the channel interrupt
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q <= SAC_RST_CTL;
		end else if (wr_lo && wr_sel == 4'h3) begin
			ctl_q <= w_data_q[3:0];
		end else if (start_wr) begin
			ctl_q[SAC_POS_MASK] <= 1'b0; // [R4]
		end
	end

	// Event enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ien_q <= SAC_RST_IEN;
		end else if (wr_lo && wr_sel == 4'h9) begin
			ien_q <= w_data_q[SAC_EVT_N-1:0];
		end
	end

	// ==========================================================
	// Prescaler
	// Strobes rather than real divided clocks keep the block in one clock domain.
	logic [SAC_PRE_W-1:0] pre_q;
	logic [1:0] tick;

	// Counter only advances while the unit clock is supplied
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q <= '0;
		end else if (gate) begin
			pre_q <= pre_q + 1'b1; // [R13]
		end
	end

	// A code of k strobes once every 2^k cycles; k of 0 strobes every cycle
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_opclk
			logic [3:0] code;
			logic [SAC_PRE_W-1:0] msk;
			assign code = (gi == 0) ? code0 : code1;
			assign msk = SAC_PRE_W'((16'h1 << code) - 16'h1);
			assign tick[gi] = gate && ((pre_q & msk) == msk); // [R3] [R13]
		end
	endgenerate

	assign op_clk.clk0 = tick[0];
	assign op_clk.clk1 = tick[1];
	assign serial_unit_clock_en = gate; // [R1]

	// ==========================================================
	// Channel state
	logic en_q; // channel_enable_status
	logic pend_q; // Channel interrupt request
	logic busy_q; // Busy handshake
	logic chan_evt; // Event picked by source select

	// Transfer end when select is 0, buffer empty when 1
	assign chan_evt = en_q && (ctl_q[SAC_POS_SRC] ? evt_i.buf_empty : evt_i.xfer_end); // [R5] [R11]

	// Enable set by trigger, cleared by stop; stop wins if both land together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_q <= 1'b0;
		end else if (stop_wr) begin
			en_q <= 1'b0; // [R12]
		end else if (start_wr) begin
			en_q <= 1'b1; // [R4]
		end
	end

	// Pending request: the enable trigger clears it, a fresh event still wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_q <= 1'b0;
		end else if (chan_evt) begin
			pend_q <= 1'b1; // [R5]
		end else if (start_wr) begin
			pend_q <= 1'b0; // [R4]
		end
	end

	// Busy rises once the master starts the final character, drops on restart or stop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q <= 1'b0;
		end else if (en_q && evt_i.last_start) begin
			busy_q <= 1'b1; // [R10]
		end else if (start_wr || stop_wr) begin
			busy_q <= 1'b0;
		end
	end

	assign channel_enable_status = en_q;
	assign tx_enable = ctl_q[SAC_POS_TXE];
	assign rx_enable = ctl_q[SAC_POS_RXE];
	assign busy_out = busy_q;
	// Software masks first before stopping, so no stray request follows a stop
	assign channel_transfer_interrupt = pend_q && !ctl_q[SAC_POS_MASK]; // [R9]

	// ==========================================================
	// Sticky events and interrupt line
	logic [SAC_EVT_N-1:0] ists_q;
	logic [SAC_EVT_N-1:0] raw_evt;
	logic [SAC_EVT_N-1:0] clr_bits;

	assign raw_evt = {evt_i.last_start, evt_i.buf_empty, evt_i.xfer_end} & {SAC_EVT_N{en_q}};
	assign clr_bits = (wr_lo && wr_sel == 4'h8) ? w_data_q[SAC_EVT_N-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ists_q <= '0;
		end else begin
			ists_q <= (ists_q & ~clr_bits) | raw_evt;
		end
	end

	assign irq = |(ists_q & ien_q);

	// ==========================================================
	// Read channel
	sac_rd_e rd_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [3:0] rd_sel;
	logic [31:0] rd_mux;

	assign rd_sel = sac_sel(s_axi_araddr);
	assign s_axi_arready = (rd_q == SAC_RD_IDLE);
	assign s_axi_rvalid = (rd_q == SAC_RD_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Read data select; write-only words read as zero
	always_comb begin
		rd_mux = 32'h0;
		case (rd_sel)
			4'h1: rd_mux[7:0] = pce_q;
			4'h2: rd_mux[7:0] = sps_q;
			4'h3: rd_mux[3:0] = ctl_q;
			4'h6: rd_mux[2:0] = {pend_q, busy_q, en_q};
			4'h7: rd_mux[SAC_EVT_N-1:0] = ists_q;
			4'h9: rd_mux[SAC_EVT_N-1:0] = ien_q;
			default: rd_mux = 32'h0;
		endcase
	end

	// Answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q <= SAC_RD_IDLE;
			rdata_q <= 32'h0;
			rresp_q <= SAC_RESP_OKAY;
		end else begin
			case (rd_q)
				SAC_RD_IDLE: begin
					if (s_axi_arvalid) begin
						rd_q <= SAC_RD_RESP;
						rdata_q <= rd_mux;
						rresp_q <= (rd_sel == 4'h0) ? SAC_RESP_SLVERR : SAC_RESP_OKAY;
					end
				end
				SAC_RD_RESP: begin
					if (s_axi_rready) begin
						rd_q <= SAC_RD_IDLE;
					end
				end
				default: rd_q <= SAC_RD_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Checks
	a_gate_clocks_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		!gate |-> (op_clk == 2'b00 && !serial_unit_clock_en))
		else $error("operation clock active while unit clock gated");
	a_gate_cnt_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
		!gate |=> (pre_q == $past(pre_q)))
		else $error("prescaler advanced while gated");
	a_code_zero_pass: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		(gate && code0 == 4'h0) |-> op_clk.clk0)
		else $error("code zero did not pass system clock");
	a_div_two_rate: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		(gate && code1 == 4'h1 && op_clk.clk1) ##1 (gate && code1 == 4'h1) |->
			!op_clk.clk1 ##1 (!(gate && code1 == 4'h1) || op_clk.clk1))
		else $error("divide by two strobe spacing wrong");
	a_start_enables: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
		(start_wr && !stop_wr && !chan_evt) |=> (en_q && !pend_q && !ctl_q[SAC_POS_MASK]))
		else $error("enable did not start, clear and unmask");
	a_stop_clears: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
		stop_wr |=> (!en_q && (!busy_q || $past(en_q && evt_i.last_start))))
		else $error("stop trigger did not clear enable");
	a_end_source: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
		(en_q && !ctl_q[SAC_POS_SRC] && evt_i.xfer_end) |=> pend_q)
		else $error("transfer end did not raise request");
	a_empty_source: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
		(en_q && ctl_q[SAC_POS_SRC] && evt_i.buf_empty) |=> pend_q)
		else $error("buffer empty did not raise request");
	a_busy_rise: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
		(en_q && evt_i.last_start) |=> busy_out)
		else $error("busy did not rise at last character");
	a_masked_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
		ctl_q[SAC_POS_MASK] |-> !channel_transfer_interrupt)
		else $error("masked channel interrupt asserted");
endmodule // sac_top
`default_nettype wire

//--- test/sac_csi_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Stand-in for the CSI master side of the data path
module sac_csi_master_model
	import sac_pkg::*;
(
	input wire logic aclk,
	output var sac_evt_s evt_i
);
	// No event pulses outside a transfer
	initial evt_i = '0;
	// One-cycle event pulse after a gap: gap 0 answers at once, a longer gap models a slow master
	// Ends one edge after the pulse so the block's sticky state has settled for the caller
	task automatic send(input logic [2:0] kind, input int gap);
		repeat (gap) @(posedge aclk);
		@(posedge aclk);
		evt_i <= sac_evt_s'(kind);
		@(posedge aclk);
		evt_i <= '0;
		@(posedge aclk);
	endtask
endmodule // sac_csi_master_model
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import sac_pkg::*;
	// ==========================================================
	// Clock, reset and bus signals
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	sac_evt_s evt_i;
	sac_opclk_s op_clk;
	logic serial_unit_clock_en, channel_enable_status, tx_enable, rx_enable, busy_out;
	logic channel_transfer_interrupt, irq;
	logic [6:0] pins; // All level outputs, gate first, irq last
	int n_errors = 0;
	int comparisons = 0;
	int c0, c1; // Strobe counts of the two operation clocks
	assign pins = {serial_unit_clock_en, channel_enable_status, tx_enable, rx_enable, busy_out,
		channel_transfer_interrupt, irq};
	// 40 MHz clock
	always #12.5 aclk = ~aclk;
	sac_top #(.ADDR_W(8)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .evt_i, .serial_unit_clock_en, .op_clk, .channel_enable_status, .tx_enable, .rx_enable,
		.busy_out, .channel_transfer_interrupt, .irq);
	sac_csi_master_model i_csi (.aclk, .evt_i);
	// ==========================================================
	// Verdict and comparisons
	task automatic give_verdict();
		if (n_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_pins(input logic [6:0] exp);
		comparisons++;
		if (pins !== exp) begin
			n_errors++;
			$display("wrong value at %0t: outputs got %h expected %h", $time, pins, exp);
		end
	endtask
	// ==========================================================
	// Bus cycles; every wait is bounded so a hung handshake ends the run
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 200) begin
			n_errors++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = SAC_RESP_OKAY);
		int n;
		bit aw, w;
		n = 0;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			tick(n);
			if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
			if (s_axi_wvalid && s_axi_wready) w = 1'b1;
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1) tick(n);
		s_axi_bready <= 1'b0;
		chk_resp(s_axi_bresp, er, "write response");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = SAC_RESP_OKAY);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tick(n);
		while (!(s_axi_arvalid && s_axi_arready)) tick(n);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) tick(n);
		s_axi_rready <= 1'b0;
		chk_val(s_axi_rdata, ed, "read data");
		chk_resp(s_axi_rresp, er, "read response");
	endtask
	// Counts strobes over a window; a window that is a multiple of 2^k gives an exact count
	task automatic count(input int cyc);
		c0 = 0;
		c1 = 0;
		repeat (cyc) begin
			@(posedge aclk);
			if (op_clk.clk0 === 1'b1) c0++;
			if (op_clk.clk1 === 1'b1) c1++;
		end
	endtask
	// ==========================================================
	// Watchdog over the whole run
	initial begin
		repeat (100000) @(posedge aclk);
		n_errors++;
		give_verdict();
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SAC_OFS_PCE, 32'h0);
		rd(SAC_OFS_SPS, 32'h0);
		rd(SAC_OFS_CTL, 32'h8);
		rd(SAC_OFS_CSTAT, 32'h0);
		rd(SAC_OFS_ISTAT, 32'h0);
		rd(SAC_OFS_IEN, 32'h0);
		rd(8'h24, 32'h0, SAC_RESP_SLVERR);
		count(64);
		chk_val(c0 + c1, 32'h0, "strobes while gated");
		wr(SAC_OFS_PCE, 32'h4);
		chk_pins(7'h40);
		// A write with no byte strobe must leave the gate on
		s_axi_wstrb <= 4'h0;
		wr(SAC_OFS_PCE, 32'h0);
		s_axi_wstrb <= 4'hF;
		chk_pins(7'h40);
		for (int k = 0; k < 6; k++) begin
			wr(SAC_OFS_SPS, 32'((k + 1) * 16 + k));
			count(64);
			chk_val(c0, 64 >> k, "clock zero strobes");
			chk_val(c1, 64 >> (k + 1), "clock one strobes");
		end
		wr(SAC_OFS_SPS, 32'hF0);
		count(32768);
		chk_val(c0, 32768, "undivided strobes");
		chk_val(c1, 1, "slowest strobes");
		wr(SAC_OFS_PCE, 32'h0);
		count(64);
		chk_val(c0 + c1, 32'h0, "strobes after gating");
		chk_pins(7'h00);
		wr(SAC_OFS_PCE, 32'h4);
		// Receive only, transfer-end timing
		wr(SAC_OFS_STOP, 32'h1);
		wr(SAC_OFS_CTL, 32'hC);
		wr(SAC_OFS_START, 32'h1);
		chk_pins(7'h68);
		rd(SAC_OFS_CTL, 32'h4);
		i_csi.send(3'h2, 0);
		chk_pins(7'h68);
		i_csi.send(3'h1, 3);
		chk_pins(7'h6A);
		rd(SAC_OFS_ISTAT, 32'h3);
		wr(SAC_OFS_START, 32'h1);
		chk_pins(7'h68);
		// Transmit only, buffer-empty timing
		wr(SAC_OFS_STOP, 32'h1);
		chk_pins(7'h48);
		wr(SAC_OFS_CTL, 32'hB);
		wr(SAC_OFS_START, 32'h1);
		i_csi.send(3'h1, 0);
		chk_pins(7'h70);
		i_csi.send(3'h2, 2);
		chk_pins(7'h72);
		// Both directions, buffer-empty timing
		wr(SAC_OFS_STOP, 32'h1);
		wr(SAC_OFS_CTL, 32'hF);
		wr(SAC_OFS_START, 32'h1);
		chk_pins(7'h78);
		i_csi.send(3'h4, 1);
		chk_pins(7'h7C);
		rd(SAC_OFS_CSTAT, 32'h3);
		// Sticky events, enable and clear
		rd(SAC_OFS_ISTAT, 32'h7);
		wr(SAC_OFS_IEN, 32'h4);
		chk_pins(7'h7D);
		wr(SAC_OFS_ICLR, 32'h4);
		chk_pins(7'h7C);
		rd(SAC_OFS_ISTAT, 32'h3);
		wr(SAC_OFS_ISTAT, 32'h0, SAC_RESP_SLVERR);
		wr(8'h30, 32'h0, SAC_RESP_SLVERR);
		wr(SAC_OFS_IEN, 32'h3);
		chk_pins(7'h7D);
		wr(SAC_OFS_ICLR, 32'h3);
		chk_pins(7'h7C);
		i_csi.send(3'h2, 0);
		chk_pins(7'h7F);
		// Shut down: mask first, then stop
		wr(SAC_OFS_CTL, 32'hF);
		chk_pins(7'h7D);
		wr(SAC_OFS_STOP, 32'h0);
		chk_pins(7'h7D);
		wr(SAC_OFS_STOP, 32'h1);
		chk_pins(7'h59);
		// Events on a stopped channel are ignored
		wr(SAC_OFS_ICLR, 32'h7);
		i_csi.send(3'h1, 0);
		rd(SAC_OFS_ISTAT, 32'h0);
		chk_pins(7'h58);
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
